/* hdl/vmd_defines.svh */
// Constants for the VMEbus slave and local map decoder.
`ifndef VMD_DEFINES_SVH
`define VMD_DEFINES_SVH

// ==========================================================
// Decode control bit positions
`define VMD_DC_ACK_FLOAT    31
`define VMD_DC_PAS_QUAL     30
`define VMD_DC_SEL1_CS_HI   29
`define VMD_DC_SEL1_CS_LO   28
`define VMD_DC_SHORT_EN     26
`define VMD_DC_LOCAL_REDIR  19
`define VMD_DC_ACK_DLY_HI   18
`define VMD_DC_ACK_DLY_LO   17

// ==========================================================
// Fixed segments, in 64-Kbyte pages; mailbox offset in 256-byte units
`define VMD_BOOT_FIRST      16'hFF00
`define VMD_BOOT_LAST       16'hFFEF
`define VMD_PROG_LAST       16'hFFFD
`define VMD_MBOX_OFFSET     8'hFF

// ==========================================================
// Reset values and counter limit
`define VMD_IRQ_ROUTE_NONE  3'h7
`define VMD_ACK_CNT_MAX     2'h3

`endif

/* hdl/vmd_pkg.sv */
// Types shared by the decoder files.
package vmd_pkg;

	// Chip select picked for a second slave select hit
	typedef enum logic [1:0] {
		VMD_CS_SHARED,
		VMD_CS_BOOT,
		VMD_CS_DRAM,
		VMD_CS_SUBSYS
	} vmd_sel1_cs_t;

	// Chip select owned by a programmable region
	typedef enum logic [1:0] {
		VMD_REG_INACTIVE,
		VMD_REG_SHARED,
		VMD_REG_SUBSYS,
		VMD_REG_SPARE
	} vmd_region_cs_t;

	// Per-region attributes
	typedef struct packed {
		vmd_region_cs_t chip_select;
		logic           cache_inhibit_n;
		logic [1:0]     address_size_code;
		logic           word_size_n;
	} vmd_region_attr_t;

	// Slave cycle tracking
	typedef enum logic [1:0] {
		VMD_ST_IDLE,
		VMD_ST_ADDR,
		VMD_ST_STROBE,
		VMD_ST_END
	} vmd_state_t;

endpackage

/* hdl/vmd_addr_match.sv */
// Masked address comparator.
`timescale 1ns/1ns
module vmd_addr_match #(
	parameter int WIDTH = 32
)(
	// Compare operands
	input  wire logic [WIDTH-1:0] i_base,
	input  wire logic [WIDTH-1:0] i_mask,
	input  wire logic [WIDTH-1:0] i_addr,
	// Result
	output wire logic             o_match
);

	// Bits with a zero mask never cause a miss
	assign o_match = ~|((i_base ^ i_addr) & i_mask);
endmodule

/* hdl/vmd_decoder.sv */
// VMEbus slave select and local memory map decoder.
`timescale 1ns/1ns
`include "vmd_defines.svh"
module vmd_decoder import vmd_pkg::*; (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// Configuration
	input  wire logic [31:0]      i_slave_base0,
	input  wire logic [31:0]      i_slave_mask0,
	input  wire logic [31:0]      i_slave_base1,
	input  wire logic [31:0]      i_slave_mask1,
	input  wire logic [15:0]      i_interproc_comm_addr,
	input  wire logic [31:0]      i_decode_ctrl,
	input  wire logic [15:0]      i_dram_upper_limit,
	input  wire logic [15:0]      i_boundary2,
	input  wire logic [15:0]      i_boundary3,
	input  wire vmd_region_attr_t i_region1_attr,
	input  wire vmd_region_attr_t i_region2_attr,
	input  wire vmd_region_attr_t i_region3_attr,
	input  wire vmd_region_attr_t i_default_attr,
	input  wire logic             i_dram_ack_external,
	input  wire logic             i_mailbox_irq_enable,
	input  wire logic [1:0]       i_mailbox_irq_route,
	input  wire logic             i_mailbox_irq_clear,
	// VMEbus address
	input  wire logic [31:0]      i_vme_addr,
	// Local bus
	input  wire logic             i_local_bus_grant_n,
	input  wire logic             i_local_address_enable,
	input  wire logic             i_processor_address_strobe_n,
	input  wire logic             i_local_write_n,
	input  wire logic [31:0]      i_local_addr,
	// Slave selects
	output logic                  o_slave_select_zero_n,
	output logic                  o_slave_select_one_n,
	output logic                  o_interproc_comm_select_n,
	// Chip selects
	output logic                  o_dram_chip_select_n,
	output logic                  o_boot_memory_select_n,
	output logic                  o_shared_resource_select_n,
	output logic                  o_subsystem_bus_select_n,
	// Upper local address, three-state
	output logic [23:0]           o_local_addr_hi,
	output logic                  o_local_addr_hi_oe,
	// Attributes
	output logic [1:0]            o_address_size_code,
	output logic                  o_word_size_n,
	output logic                  o_cache_inhibit_n,
	// Size acknowledge, three-state
	output logic [1:0]            o_size_acknowledge_n,
	output logic                  o_size_acknowledge_oe,
	// Local interrupts
	output logic [2:0]            o_local_irq_n
);

	// ==========================================================
	// Control fields
	wire logic         ack_float;
	wire logic         pas_qual;
	wire vmd_sel1_cs_t sel1_cs;
	wire logic         short_en;
	wire logic         local_redir;
	wire logic [1:0]   ack_delay;
	assign ack_float   = i_decode_ctrl[`VMD_DC_ACK_FLOAT];
	assign pas_qual    = i_decode_ctrl[`VMD_DC_PAS_QUAL];
	assign sel1_cs     = vmd_sel1_cs_t'(i_decode_ctrl[`VMD_DC_SEL1_CS_HI:`VMD_DC_SEL1_CS_LO]);
	assign short_en    = i_decode_ctrl[`VMD_DC_SHORT_EN];
	assign local_redir = i_decode_ctrl[`VMD_DC_LOCAL_REDIR];
	assign ack_delay   = i_decode_ctrl[`VMD_DC_ACK_DLY_HI:`VMD_DC_ACK_DLY_LO];

	// ==========================================================
	// Registers
	vmd_state_t  st_r;
	vmd_state_t  st_nxt;
	logic        cyc_sel0_r;
	logic        cyc_sel1_r;
	logic        forced_boot_r;
	logic [1:0]  ack_cnt_r;
	logic        ack_r;
	logic        mbox_irq_r;

	// ==========================================================
	// Slave select compares
	wire logic m0_vme;
	wire logic m1_vme;
	wire logic m1_short;
	wire logic m0_local;

	vmd_addr_match #(.WIDTH(32)) u_m0_vme (
		.i_base  (i_slave_base0),
		.i_mask  (i_slave_mask0),
		.i_addr  (i_vme_addr),
		.o_match (m0_vme)
	);
	vmd_addr_match #(.WIDTH(32)) u_m1_vme (
		.i_base  (i_slave_base1),
		.i_mask  (i_slave_mask1),
		.i_addr  (i_vme_addr),
		.o_match (m1_vme)
	);
	// Short space uses the top byte of the second base and mask
	vmd_addr_match #(.WIDTH(8)) u_m1_short (
		.i_base  (i_slave_base1[31:24]),
		.i_mask  (i_slave_mask1[31:24]),
		.i_addr  (i_vme_addr[15:8]),
		.o_match (m1_short)
	);
	// Local bus view of the first slave window
	vmd_addr_match #(.WIDTH(32)) u_m0_local (
		.i_base  (i_slave_base0),
		.i_mask  (i_slave_mask0),
		.i_addr  (i_local_addr),
		.o_match (m0_local)
	);

	// Select combination and interlock; select zero locks out select one except in short space
	wire logic sel0_hit;
	wire logic sel1_raw;
	wire logic sel1_hit;
	wire logic icomm_hit;
	assign sel0_hit  = m0_vme;
	assign sel1_raw  = short_en ? m1_short : m1_vme;
	assign sel1_hit  = sel1_raw && (!sel0_hit || short_en);
	assign icomm_hit = (i_vme_addr[15:8] == i_interproc_comm_addr[15:8]) ||
		(i_vme_addr[15:8] == i_interproc_comm_addr[7:0]);

	// ==========================================================
	// Slave cycle sequencing
	wire logic slave_active;
	wire logic pas_on;
	assign slave_active = !i_local_bus_grant_n && i_local_address_enable;
	assign pas_on       = !i_processor_address_strobe_n;

	// Cycle phases: address out, strobed, floated until the enable drops
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			VMD_ST_IDLE: begin
				if (slave_active)
					st_nxt = VMD_ST_ADDR;
			end
			VMD_ST_ADDR: begin
				if (!slave_active)
					st_nxt = VMD_ST_IDLE;
				else if (pas_on)
					st_nxt = VMD_ST_STROBE;
			end
			VMD_ST_STROBE: begin
				if (!pas_on)
					st_nxt = slave_active ? VMD_ST_END : VMD_ST_IDLE;
			end
			VMD_ST_END: begin
				if (!slave_active)
					st_nxt = VMD_ST_IDLE;
			end
			default: st_nxt = VMD_ST_IDLE;
		endcase
	end

	wire logic in_slave;
	wire logic slave_strobed;
	wire logic drive_addr;
	assign in_slave      = (st_r != VMD_ST_IDLE);
	assign slave_strobed = (st_r == VMD_ST_STROBE) && pas_on;
	assign drive_addr    = (st_nxt == VMD_ST_ADDR) || (st_nxt == VMD_ST_STROBE);

	// ==========================================================
	// Local map decode on 64-Kbyte pages
	wire logic [23:0] eff_hi;
	wire logic [15:0] page;
	assign eff_hi = in_slave ? o_local_addr_hi : i_local_addr[31:8];
	assign page   = eff_hi[23:8];

	wire logic dram_range;
	wire logic boot_seg;
	wire logic in_r1;
	wire logic in_r2;
	wire logic in_r3;
	assign dram_range = &(~(i_dram_upper_limit & page));
	assign boot_seg   = (page >= `VMD_BOOT_FIRST) && (page <= `VMD_BOOT_LAST);
	assign in_r1 = (page >= i_dram_upper_limit) && (page < i_boundary2);
	assign in_r2 = (page >= i_boundary2) && (page < i_boundary3);
	assign in_r3 = (page >= i_boundary3) && (page <= `VMD_PROG_LAST);

	// Region attribute selection
	wire vmd_region_attr_t reg_attr;
	wire logic             in_region;
	assign in_region = in_r1 || in_r2 || in_r3;
	assign reg_attr  = in_r1 ? i_region1_attr :
		in_r2 ? i_region2_attr :
		in_r3 ? i_region3_attr : i_default_attr;

	// Processor-side selects; forced boot mode overrides DRAM, low block included
	wire logic proc_dram;
	wire logic proc_strobe_ok;
	assign proc_dram      = !forced_boot_r &&
		((dram_range && !in_region) || (local_redir && m0_local));
	assign proc_strobe_ok = !pas_qual || pas_on;

	// Slave-side selects, raised only once strobes are on
	wire logic slave_dram;
	wire logic slave_other;
	assign slave_dram  = (cyc_sel0_r && local_redir) ||
		(cyc_sel1_r && !cyc_sel0_r && sel1_cs == VMD_CS_DRAM);
	assign slave_other = cyc_sel1_r && !cyc_sel0_r;

	wire logic dram_nxt;
	wire logic boot_nxt;
	wire logic shared_nxt;
	wire logic subsys_nxt;
	assign dram_nxt   = in_slave ? (slave_strobed && slave_dram) :
		(proc_dram && proc_strobe_ok);
	assign boot_nxt   = in_slave ? (slave_strobed && slave_other && sel1_cs == VMD_CS_BOOT) :
		(pas_on && (boot_seg || forced_boot_r));
	assign shared_nxt = in_slave ? (slave_strobed && slave_other && sel1_cs == VMD_CS_SHARED) :
		(pas_on && in_region && reg_attr.chip_select == VMD_REG_SHARED);
	assign subsys_nxt = in_slave ? (slave_strobed && slave_other && sel1_cs == VMD_CS_SUBSYS) :
		(pas_on && in_region && reg_attr.chip_select == VMD_REG_SUBSYS);

	// ==========================================================
	// Acknowledge: counts clocks from DRAM select, holds until strobe ends
	wire logic ack_nxt;
	wire logic ack_oe_nxt;
	assign ack_nxt    = pas_on && !o_dram_chip_select_n && (ack_r || ack_cnt_r == ack_delay);
	assign ack_oe_nxt = pas_on && dram_nxt && !i_dram_ack_external &&
		!(ack_float && i_local_address_enable && in_slave);

	// ==========================================================
	// Mailbox: top page below the limit, top 256-byte offset
	wire logic mbox_hit;
	wire logic mbox_set;
	assign mbox_hit = (eff_hi[23:8] == i_dram_upper_limit - 16'h0001) &&
		(eff_hi[7:0] == `VMD_MBOX_OFFSET);
	assign mbox_set = i_mailbox_irq_enable && cyc_sel0_r && !i_local_write_n &&
		(st_r == VMD_ST_ADDR) && pas_on && mbox_hit;

	// ==========================================================
	// Cycle state and latched slave address
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_r            <= VMD_ST_IDLE;
			cyc_sel0_r      <= 1'b0;
			cyc_sel1_r      <= 1'b0;
			o_local_addr_hi <= 24'h00_0000;
		end else begin
			st_r <= st_nxt;
			if (st_r == VMD_ST_IDLE && slave_active) begin
				cyc_sel0_r      <= sel0_hit;
				cyc_sel1_r      <= sel1_hit;
				o_local_addr_hi <= i_vme_addr[31:8];
			end
		end
	end

	// Forced boot mode leaves on the first boot segment access
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			forced_boot_r <= 1'b1;
		else if (!in_slave && pas_on && boot_seg)
			forced_boot_r <= 1'b0;
	end

	// Selects, recomputed every clock as the address moves
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_slave_select_zero_n     <= 1'b1;
			o_slave_select_one_n      <= 1'b1;
			o_interproc_comm_select_n <= 1'b1;
		end else begin
			o_slave_select_zero_n     <= !sel0_hit;
			o_slave_select_one_n      <= !sel1_hit;
			o_interproc_comm_select_n <= !icomm_hit;
		end
	end

	// Chip selects and address enable
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_dram_chip_select_n       <= 1'b1;
			o_boot_memory_select_n     <= 1'b1;
			o_shared_resource_select_n <= 1'b1;
			o_subsystem_bus_select_n   <= 1'b1;
			o_local_addr_hi_oe         <= 1'b0;
		end else begin
			o_dram_chip_select_n       <= !dram_nxt;
			o_boot_memory_select_n     <= !boot_nxt;
			o_shared_resource_select_n <= !shared_nxt;
			o_subsystem_bus_select_n   <= !subsys_nxt;
			o_local_addr_hi_oe         <= drive_addr;
		end
	end

	// Attributes follow the strobe; idle values come from the default set
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_address_size_code <= 2'h0;
			o_word_size_n       <= 1'b1;
			o_cache_inhibit_n   <= 1'b1;
		end else begin
			o_address_size_code <= pas_on ? reg_attr.address_size_code : i_default_attr.address_size_code;
			o_word_size_n       <= pas_on ? reg_attr.word_size_n : i_default_attr.word_size_n;
			o_cache_inhibit_n   <= pas_on ? reg_attr.cache_inhibit_n : i_default_attr.cache_inhibit_n;
		end
	end

	// Acknowledge delay counter saturates so a long strobe cannot wrap it
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ack_cnt_r             <= 2'h0;
			ack_r                 <= 1'b0;
			o_size_acknowledge_n  <= 2'h3;
			o_size_acknowledge_oe <= 1'b0;
		end else begin
			if (o_dram_chip_select_n)
				ack_cnt_r <= 2'h0;
			else if (ack_cnt_r != `VMD_ACK_CNT_MAX)
				ack_cnt_r <= ack_cnt_r + 2'h1;
			ack_r                 <= ack_nxt;
			o_size_acknowledge_n  <= ack_nxt ? 2'h0 : 2'h3;
			o_size_acknowledge_oe <= ack_oe_nxt;
		end
	end

	// Mailbox interrupt: sticky, a new hit beats a same-cycle clear
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			mbox_irq_r <= 1'b0;
		else if (mbox_set)
			mbox_irq_r <= 1'b1;
		else if (i_mailbox_irq_clear)
			mbox_irq_r <= 1'b0;
	end

	// Route onto the configured line; code 3 leaves all lines quiet
	wire logic [2:0] irq_lines;
	assign irq_lines = mbox_set || mbox_irq_r ?
		(i_mailbox_irq_route == 2'h0 ? 3'h6 : i_mailbox_irq_route == 2'h1 ? 3'h5 :
		i_mailbox_irq_route == 2'h2 ? 3'h3 : `VMD_IRQ_ROUTE_NONE) : `VMD_IRQ_ROUTE_NONE;
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			o_local_irq_n <= `VMD_IRQ_ROUTE_NONE;
		else
			o_local_irq_n <= irq_lines;
	end
endmodule

/* verif/vmd_decoder_properties.sv */
// Port-level assertions for the decoder.
`timescale 1ns/1ns
module vmd_decoder_properties (
	// Clock, reset and inputs
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic [31:0] i_slave_base0,
	input wire logic [31:0] i_slave_mask0,
	input wire logic [31:0] i_decode_ctrl,
	input wire logic        i_dram_ack_external,
	input wire logic [31:0] i_vme_addr,
	input wire logic        i_local_bus_grant_n,
	input wire logic        i_local_address_enable,
	input wire logic        i_processor_address_strobe_n,
	// Outputs watched
	input wire logic        o_slave_select_zero_n,
	input wire logic        o_slave_select_one_n,
	input wire logic        o_dram_chip_select_n,
	input wire logic [23:0] o_local_addr_hi,
	input wire logic        o_local_addr_hi_oe,
	input wire logic [1:0]  o_size_acknowledge_n,
	input wire logic        o_size_acknowledge_oe
);
	// ========
	// Helpers: reset history, cycles since DRAM select fell
	logic       rst_r;
	logic [2:0] cnt_r;
	wire        m0 = ((i_slave_base0 ^ i_vme_addr) & i_slave_mask0) == 32'h0000_0000;
	always_ff @(posedge i_clk) rst_r <= i_resetn;
	// Saturates, so a long select never wraps to a false match
	always_ff @(posedge i_clk) cnt_r <= (!i_resetn || o_dram_chip_select_n) ? 3'h0 : cnt_r + 3'(cnt_r != 3'h7);
	default clocking cb @(posedge i_clk); endclocking
	// First edge after reset still sees reset-time inputs
	default disable iff (!i_resetn || !rst_r);
	sequence s_release; $rose(i_processor_address_strobe_n); endsequence
	sequence s_idle; o_size_acknowledge_n == 2'h3 && !o_size_acknowledge_oe && !o_local_addr_hi_oe; endsequence
	sequence s_ack_on; $past(o_size_acknowledge_n) == 2'h3 && o_size_acknowledge_n == 2'h0; endsequence
	// ========
	// Assertions
	AST_SEL0: assert property (o_slave_select_zero_n == !$past(m0))
		else $error("select zero wrong");
	AST_SEL1_LOCK: assert property ($past(m0 && !i_decode_ctrl[26]) |-> o_slave_select_one_n)
		else $error("select one not locked out");
	AST_HI_DRIVE: assert property ($rose(o_local_addr_hi_oe) |->
		$past(!i_local_bus_grant_n && i_local_address_enable) && o_local_addr_hi == $past(i_vme_addr[31:8]))
		else $error("upper address wrong");
	AST_RELEASE: assert property (s_release |=> s_idle)
		else $error("cycle end not released");
	AST_DRAM_QUAL: assert property ($past(i_decode_ctrl[30] && i_processor_address_strobe_n) |-> o_dram_chip_select_n)
		else $error("dram select without strobe");
	AST_ACK_DELAY: assert property (s_ack_on ##0 !o_dram_chip_select_n |-> cnt_r == {1'b0, i_decode_ctrl[18:17]} + 3'h1)
		else $error("ack delay wrong");
	AST_ACK_FLOAT: assert property ($past(i_decode_ctrl[31] && i_local_address_enable) |-> !o_size_acknowledge_oe)
		else $error("ack driven while floated");
	AST_ACK_EXT: assert property ($past(i_dram_ack_external) && !o_dram_chip_select_n |-> !o_size_acknowledge_oe)
		else $error("ack driven for external end");
	AST_ACK_WIDTH: assert property (o_size_acknowledge_oe |->
		!o_dram_chip_select_n && ^o_size_acknowledge_n == 1'b0)
		else $error("dram ack not 32-bit");
endmodule
bind vmd_decoder vmd_decoder_properties u_props (.*);

/* verif/vmd_far_side.sv */
// Far-side model: bus controller, arbiter and processor strobes.
`timescale 1ns/1ns
module vmd_far_side (
	// Control from the bench
	input wire logic       i_clk,
	input wire logic       i_go,
	input wire logic       i_slave,
	input wire logic       i_write_n,
	input wire logic       i_slow,
	// Decoder answers
	input wire logic [1:0] i_ack_n,
	input wire logic       i_hi_oe,
	// Local bus side
	output logic           o_grant_n,
	output logic           o_enable,
	output logic           o_strobe_n,
	output logic           o_write_n,
	output logic           o_busy
);
	int n;
	initial {o_grant_n, o_enable, o_strobe_n, o_write_n, o_busy} = 5'h16;
	// One transfer per go; waits are bounded so a dead decoder cannot hang it
	always begin
		do @(posedge i_clk); while (!i_go);
		o_busy <= 1'b1;
		o_write_n <= i_write_n;
		if (i_slave) begin
			o_grant_n <= 1'b0;
			o_enable <= 1'b1;
			for (n = 0; !i_hi_oe && n < 8; n++) @(posedge i_clk);
		end
		o_strobe_n <= 1'b0;
		// No acknowledge: the ack timeout ends the cycle
		for (n = 0; i_ack_n != 2'h0 && n < 8; n++) @(posedge i_clk);
		repeat (i_slow ? 3 : 0) @(posedge i_clk);
		o_strobe_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_enable <= 1'b0;
		o_grant_n <= 1'b1;
		@(posedge i_clk);
		o_busy <= 1'b0;
	end
endmodule

/* verif/vmd_decoder_bench.sv */
// Self-checking bench for the decoder.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module vmd_decoder_bench import vmd_pkg::*; ;
	// ========
	// Stimulus, model wires and monitors
	typedef struct packed {logic [31:0] b0, m0, b1, m1, c, a; logic [2:0] e;} vmd_row_t;
	logic clk = 1'b0, rstn = 1'b0, ack_ext = 1'b0, irq_en = 1'b0, irq_clr = 1'b0;
	logic go = 1'b0, slv = 1'b0, wr = 1'b1, slow = 1'b0, clr = 1'b0;
	logic [31:0] b0 = '0, m0 = '0, b1 = '0, m1 = '0, ctl = '0, va = '0, pa = '0;
	logic [15:0] icf = 16'hAA55, lim = 16'h0010, bd2 = 16'h0100, bd3 = 16'h0400;
	logic [1:0] rte = 2'h0;
	vmd_region_attr_t r1 = '{VMD_REG_SHARED, 1'b1, 2'h1, 1'b1}, r2 = '{VMD_REG_SUBSYS, 1'b1, 2'h2, 1'b1};
	vmd_region_attr_t r3 = '{VMD_REG_INACTIVE, 1'b0, 2'h3, 1'b0}, rd = '{VMD_REG_INACTIVE, 1'b1, 2'h0, 1'b1};
	wire gnt_n, en, pas_n, wn, busy, s0, s1, icn, dn, bn, sn, vn, hoe, aoe, ci, wsz;
	wire [23:0] hi;
	wire [1:0] ack, asz;
	wire [2:0] irq;
	// Undriven upper lines show the inverse, not a stale copy
	wire [31:0] la = hoe ? {hi, 8'h00} : (en ? ~pa : pa);
	// Released acknowledge lines float up to their pull-up level
	wire [1:0] ack_bus = aoe ? ack : 2'h3;
	logic [3:0] seen;
	logic ack_seen, ci_seen, ws_seen;
	logic [23:0] hi_seen;
	logic [1:0] asz_seen;
	int error_cnt = 0, compares = 0, n;
	vmd_row_t rows [6] = '{
		'{32'h1234_0000, 32'hFFFF_0000, 32'h5600_0000, 32'hFF00_0000, 32'h0000_0000, 32'h1234_5600, 3'h3},
		'{32'h1234_0000, 32'hFF00_0000, 32'h5600_0000, 32'hFF00_0000, 32'h0000_0000, 32'h12FF_AA00, 3'h2},
		'{32'h1234_0000, 32'hFFFF_0000, 32'h5600_0000, 32'hFF00_0000, 32'h0000_0000, 32'h3400_5500, 3'h6},
		'{32'h1234_0000, 32'hFFFF_0000, 32'h5600_0000, 32'hFF00_0000, 32'h0000_0000, 32'h5600_0000, 3'h5},
		'{32'h1234_0000, 32'h0000_0000, 32'h5600_0000, 32'hFF00_0000, 32'h0000_0000, 32'h5600_0000, 3'h3},
		'{32'h1234_0000, 32'hFFFF_0000, 32'h5600_0000, 32'hFF00_0000, 32'h0400_0000, 32'h1234_5600, 3'h1}};
	logic [31:0] pas [8] = '{32'h0000_0000, 32'hFF00_0000, 32'h0000_0000, 32'h0010_0000,
		32'h0200_0000, 32'h0001_0000, 32'h0800_0000, 32'h1234_0000};
	logic [3:0] pexp [8] = '{4'h2, 4'h2, 4'h1, 4'h4, 4'h8, 4'h1, 4'h0, 4'h0};
	logic [3:0] s1e [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
	logic [31:0] scl [3] = '{32'h4000_0000, 32'hC008_0000, 32'h4008_0000};
	vmd_decoder uut (.i_clk(clk), .i_resetn(rstn), .i_slave_base0(b0), .i_slave_mask0(m0),
		.i_slave_base1(b1), .i_slave_mask1(m1), .i_interproc_comm_addr(icf), .i_decode_ctrl(ctl),
		.i_dram_upper_limit(lim), .i_boundary2(bd2), .i_boundary3(bd3), .i_region1_attr(r1),
		.i_region2_attr(r2), .i_region3_attr(r3), .i_default_attr(rd), .i_dram_ack_external(ack_ext),
		.i_mailbox_irq_enable(irq_en), .i_mailbox_irq_route(rte), .i_mailbox_irq_clear(irq_clr),
		.i_vme_addr(va), .i_local_bus_grant_n(gnt_n), .i_local_address_enable(en),
		.i_processor_address_strobe_n(pas_n), .i_local_write_n(wn), .i_local_addr(la),
		.o_slave_select_zero_n(s0), .o_slave_select_one_n(s1), .o_interproc_comm_select_n(icn),
		.o_dram_chip_select_n(dn), .o_boot_memory_select_n(bn), .o_shared_resource_select_n(sn),
		.o_subsystem_bus_select_n(vn), .o_local_addr_hi(hi), .o_local_addr_hi_oe(hoe),
		.o_address_size_code(asz), .o_word_size_n(wsz), .o_cache_inhibit_n(ci),
		.o_size_acknowledge_n(ack), .o_size_acknowledge_oe(aoe), .o_local_irq_n(irq));
	vmd_far_side far (.i_clk(clk), .i_go(go), .i_slave(slv), .i_write_n(wr), .i_slow(slow),
		.i_ack_n(ack_bus), .i_hi_oe(hoe), .o_grant_n(gnt_n), .o_enable(en), .o_strobe_n(pas_n),
		.o_write_n(wn), .o_busy(busy));
	always #5 clk = ~clk;
	// Record what each transfer showed; selects, ack and upper address cleared at its start
	always @(posedge clk) begin
		if (clr) begin
			seen <= 4'h0;
			ack_seen <= 1'b0;
			hi_seen <= 24'h00_0000;
		end else begin
			seen <= seen | ~{vn, sn, bn, dn};
			ack_seen <= ack_seen | (aoe && ack == 2'h0);
			if (hoe) hi_seen <= hi;
			if (!pas_n) {asz_seen, ci_seen, ws_seen} <= {asz, ci, wsz};
		end
	end
	// ========
	// Transfer and closing tasks
	task automatic xfer(input logic s, input logic w);
		@(posedge clk);
		{clr, slv, wr, go} <= {1'b1, s, w, 1'b1};
		@(posedge clk);
		{clr, go} <= 2'h0;
		@(posedge clk);
		for (n = 0; busy === 1'b1 && n < 60; n++) @(posedge clk);
		#1;
		`CHK("transfer done", 1'b0, busy)
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Tests take about five hundred cycles; wide margin
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	// ========
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1 `CHK("reset outputs", {7'h7F, 2'h0, 3'h7}, {s0, s1, icn, dn, bn, sn, vn, hoe, aoe, irq})
		$display("test reset done");
		@(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			{b0, m0, b1, m1, ctl, va} <= rows[i][194:3];
			repeat (2) @(posedge clk);
			#1 `CHK("slave selects", rows[i].e, {s0, s1, icn})
		end
		$display("test select table done");
		// Forced boot first, then the page map
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{ctl, pa} <= {32'h4000_0000, pas[i]};
			xfer(1'b0, 1'b1);
			`CHK("processor selects", pexp[i], seen)
		end
		`CHK("region attributes", 4'hC, {asz_seen, ci_seen, ws_seen})
		// Local view of the first slave window reaches DRAM once enabled
		@(posedge clk);
		{ctl, pa} <= {32'h4008_0000, 32'h1234_0000};
		xfer(1'b0, 1'b1);
		`CHK("local recognition", 4'h1, seen)
		@(posedge clk);
		{pa, ctl} <= 64'h0;
		repeat (3) @(posedge clk);
		#1 `CHK("unqualified dram select", 1'b0, dn)
		@(posedge clk);
		ctl <= 32'h4000_0000;
		repeat (3) @(posedge clk);
		#1 `CHK("qualified dram select", 1'b1, dn)
		$display("test local map done");
		// Delays 0..3, redirection off, ack float, external end
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			{b0, m0, b1, m1, va} <= {rows[0].b0, rows[0].m0, rows[0].b1, rows[0].m1, rows[0].a};
			ctl <= (i < 4) ? (32'h4008_0000 | (32'(i) << 17)) : scl[i - 4];
			{ack_ext, slow} <= {i == 6, i[0]};
			xfer(1'b1, 1'b1);
			`CHK("dram and ack", (i < 4) ? 2'h3 : ((i == 4) ? 2'h0 : 2'h2), {seen[0], ack_seen})
			`CHK("upper address", 24'h12_3456, hi_seen)
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			{ack_ext, va, ctl} <= {1'b0, 32'h5600_0000, 32'h4000_0000 | (32'(k) << 28)};
			xfer(1'b1, 1'b1);
			`CHK("second select target", s1e[k], seen)
		end
		$display("test slave cycles done");
		// Routes 0..2, no line, then a read
		for (int r = 0; r < 5; r++) begin
			@(posedge clk);
			{b0, m0, va, irq_en, ctl} <= {32'h0000_0000, 32'hFFF0_0000, 32'h000F_FF00, 1'b1, 32'h4008_0000};
			rte <= r[1:0];
			xfer(1'b1, r == 4);
			`CHK("mailbox interrupt", (r < 3) ? ~(3'h1 << r) : 3'h7, irq)
			@(posedge clk);
			irq_clr <= 1'b1;
			@(posedge clk);
			irq_clr <= 1'b0;
			repeat (2) @(posedge clk);
			#1 `CHK("interrupt cleared", 3'h7, irq)
		end
		$display("test mailbox done");
		summarize();
	end
endmodule
